/* dv/test_usb_host_global_control_irq.sv */
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin errors++; \
  $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module test_usb_host_global_control_irq
  import uhg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [ADR_W-1:0] adr_i = '0;
  logic [3:0] sel_i = 4'h0;
  logic [DAT_W-1:0] dat_i = '0, dat_o, rd;
  logic ack_o, irq_o, slow = 1'b0;
  logic [2:0] ev_req = 3'h0;
  logic [NUM_PIPES-1:0] pipe_irq = '0;
  uhg_line_evt_t line_evt;
  uhg_line_cmd_t line_cmd;
  int errors = 0, n_checks = 0;
  localparam logic [DAT_W-1:0] ALL_EN = {15'h0000, EN_MASK};

  always #12.5 clk_i = ~clk_i;

  uhg_host_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .line_evt_i(line_evt), .pipe_irq_i(pipe_irq), .line_cmd_o(line_cmd), .irq_o(irq_o));
  uhg_line_model peer (.clk_i(clk_i), .rst_i(rst_i), .line_cmd_i(line_cmd),
    .ev_req_i(ev_req), .slow_i(slow), .line_evt_o(line_evt));

  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report

  task automatic wait_ack;
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    `CHK("ack", 1'b1, ack_o)
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask : wait_ack

  task automatic wr(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= 1'b1;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    wait_ack();
  endtask : wr

  task automatic rdc(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] e,
                     input string nm, input logic [DAT_W-1:0] m = 32'hffff_ffff);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= 1'b0;
    adr_i <= a;
    sel_i <= 4'hf;
    wait_ack();
    `CHK(nm, e, rd & m)
  endtask : rdc

  task automatic ev(input logic [2:0] b);
    @(posedge clk_i);
    ev_req <= b;
    @(posedge clk_i);
    ev_req <= 3'h0;
    repeat (3) @(posedge clk_i);
  endtask : ev

  task automatic wait_idle;
    int n;
    n = 0;
    while ((line_cmd.send_reset | line_cmd.send_resume) !== 1'b0 && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    `CHK("sequence end", 1'b0, line_cmd.send_reset | line_cmd.send_resume)
    repeat (2) @(posedge clk_i);
  endtask : wait_idle

  task automatic done_t(input string s);
    $display("test %s done", s);
  endtask : done_t

  initial begin
    repeat (5000) @(posedge clk_i);
    errors++;
    final_report();
  end

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(OFF_FLAGS, 32'h0, "flags reset");
    rdc(OFF_ENABLES, 32'h0, "enables reset");
    rdc(OFF_BUS_CTRL, 32'h0, "ctrl reset");
    rdc(12'h47c, 32'h0, "unmapped");
    `CHK("irq reset", 1'b0, irq_o)
    done_t("reset");
    wr(OFF_ENABLE_SET, 32'hffff_ffff);
    wr(OFF_ENABLES, 32'h0);
    rdc(OFF_ENABLES, ALL_EN, "enables ro");
    for (int i = 0; i < NUM_EVT; i++) begin
      wr(OFF_FLAG_SET, 32'h1 << i);
      wr(OFF_FLAG_CLR, 32'h0);
      rdc(OFF_FLAGS, 32'h1 << i, "flag set");
      `CHK("irq flag", 1'b1, irq_o)
      wr(OFF_FLAG_CLR, 32'h1 << i);
      rdc(OFF_FLAGS, 32'h0, "flag clear");
      `CHK("irq none", 1'b0, irq_o)
    end
    wr(OFF_FLAG_SET, 32'h1);
    wr(OFF_ENABLE_CLR, 32'h1);
    rdc(OFF_ENABLES, ALL_EN & ~32'h1, "enable clear");
    `CHK("irq masked", 1'b0, irq_o)
    wr(OFF_ENABLE_SET, 32'h1);
    wr(OFF_FLAG_CLR, 32'h7f);
    done_t("flags");
    pipe_irq <= 9'h101;
    repeat (3) @(posedge clk_i);
    rdc(OFF_FLAGS, 32'h1_0100, "pipe flags");
    `CHK("irq pipe", 1'b1, irq_o)
    pipe_irq <= 9'h000;
    repeat (3) @(posedge clk_i);
    rdc(OFF_FLAGS, 32'h0, "pipe served");
    done_t("pipes");
    wr(OFF_BUS_CTRL, 32'h200);
    rdc(OFF_BUS_CTRL, 32'h300, "reset req");
    wait_idle();
    rdc(OFF_FLAGS, 32'h04, "reset done", 32'h1f);
    rdc(OFF_BUS_CTRL, 32'h100, "reset clr");
    `CHK("sof gen", 1'b1, line_cmd.sof_gen)
    repeat (10) @(posedge clk_i);
    rdc(OFF_FLAGS, 32'h20, "frame flag", 32'h20);
    wr(OFF_FLAG_CLR, 32'h7f);
    wr(OFF_BUS_CTRL, 32'h500);
    @(posedge clk_i);
    `CHK("resume cmd", 1'b1, line_cmd.send_resume)
    wr(OFF_BUS_CTRL, 32'h100);
    @(posedge clk_i);
    `CHK("resume kept", 1'b1, line_cmd.send_resume)
    wait_idle();
    rdc(OFF_FLAGS, 32'h08, "resume done", 32'h1f);
    rdc(OFF_BUS_CTRL, 32'h100, "resume clr");
    wr(OFF_BUS_CTRL, 32'h100);
    @(posedge clk_i);
    `CHK("resume zero", 1'b0, line_cmd.send_resume)
    done_t("reset and resume");
    slow <= 1'b1;
    wr(OFF_FLAG_CLR, 32'h7f);
    wr(OFF_BUS_CTRL, 32'h500);
    wr(OFF_BUS_CTRL, 32'h200);
    rdc(OFF_BUS_CTRL, 32'h300, "resume by reset");
    ev(3'b010);
    rdc(OFF_FLAGS, 32'h02, "detach", 32'h5f);
    wr(OFF_BUS_CTRL, 32'h100);
    @(posedge clk_i);
    `CHK("reset abort", 1'b0, line_cmd.send_reset)
    repeat (60) @(posedge clk_i);
    rdc(OFF_FLAGS, 32'h02, "no reset done", 32'h1f);
    slow <= 1'b0;
    done_t("abort");
    wr(OFF_AUX_CTRL, 32'h4);
    @(posedge clk_i);
    `CHK("keepalive", 1'b1, line_cmd.keepalive_gen)
    `CHK("no sof low", 1'b0, line_cmd.sof_gen)
    wr(OFF_FLAG_CLR, 32'h7f);
    repeat (10) @(posedge clk_i);
    rdc(OFF_FLAGS, 32'h20, "keepalive flag", 32'h20);
    wr(OFF_BUS_CTRL, 32'h0);
    @(posedge clk_i);
    `CHK("suspend", 1'b0, line_cmd.keepalive_gen)
    wr(OFF_FLAG_CLR, 32'h7f);
    repeat (20) @(posedge clk_i);
    rdc(OFF_FLAGS, 32'h0, "idle bus");
    done_t("frames");
    wr(OFF_AUX_CTRL, 32'h2);
    @(posedge clk_i);
    `CHK("freeze cmd", 1'b1, line_cmd.clock_freeze)
    ev(3'b001);
    rdc(OFF_FLAGS, 32'h40, "frozen wakeup");
    rdc(OFF_BUS_CTRL, 32'h0, "frozen ctrl");
    wr(OFF_AUX_CTRL, 32'h0);
    wr(OFF_FLAG_CLR, 32'h7f);
    ev(3'b001);
    rdc(OFF_FLAGS, 32'h50, "up resume", 32'h5f);
    rdc(OFF_BUS_CTRL, 32'h100, "resume sets sof");
    wr(OFF_BUS_CTRL, 32'h0);
    wr(OFF_FLAG_CLR, 32'h7f);
    ev(3'b010);
    rdc(OFF_FLAGS, 32'h42, "detach wakeup");
    wr(OFF_FLAG_CLR, 32'h7f);
    wr(OFF_AUX_CTRL, 32'h1);
    rdc(OFF_AUX_CTRL, 32'h1, "aux ctrl");
    `CHK("bus power cmd", 1'b1, line_cmd.bus_power)
    ev(3'b100);
    rdc(OFF_FLAGS, 32'h41, "attach wakeup");
    wr(OFF_FLAG_CLR, 32'h7f);
    wr(OFF_AUX_CTRL, 32'h0);
    ev(3'b100);
    rdc(OFF_FLAGS, 32'h01, "attach only");
    done_t("wakeup");
    final_report();
  end
endmodule : test_usb_host_global_control_irq

/* dv/uhg_line_model.sv */
module uhg_line_model
  import uhg_pkg::*;
(
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Commands from the host block
  input  wire uhg_line_cmd_t line_cmd_i,
  // Bench requests: attach, detach, upstream resume
  input  wire logic [2:0]    ev_req_i,
  input  wire logic          slow_i,
  // Line events to the host block
  output uhg_line_evt_t      line_evt_o
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] rst_cnt;
  logic [7:0] rsm_cnt;
  logic [7:0] frm_cnt;
  logic [7:0] lim;

  // Slow mode stretches every line sequence
  assign lim = slow_i ? 8'h28 : 8'h06;

  always_ff @(posedge clk_i) begin
    line_evt_o <= '0;
    if (rst_i) begin
      rst_cnt <= 8'h00;
      rsm_cnt <= 8'h00;
      frm_cnt <= 8'h00;
    end else begin
      line_evt_o.attach    <= ev_req_i[2];
      line_evt_o.detach    <= ev_req_i[1];
      line_evt_o.up_resume <= ev_req_i[0];
      rst_cnt <= line_cmd_i.send_reset ? rst_cnt + 8'h01 : 8'h00;
      line_evt_o.reset_sent <= line_cmd_i.send_reset && (rst_cnt == lim);
      rsm_cnt <= line_cmd_i.send_resume ? rsm_cnt + 8'h01 : 8'h00;
      line_evt_o.resume_sent <= line_cmd_i.send_resume && (rsm_cnt == lim);
      if (line_cmd_i.sof_gen || line_cmd_i.keepalive_gen) begin
        // Wrap also when a mode change leaves the count past the limit
        frm_cnt <= (frm_cnt >= lim) ? 8'h00 : frm_cnt + 8'h01;
        line_evt_o.frame_sent <= (frm_cnt >= lim);
      end else begin
        frm_cnt <= 8'h00;
      end
    end
  end
endmodule : uhg_line_model

/* logic/uhg_host_ctrl.sv */
// Overview of operation
// - Writing one to resume request starts a downstream resume; zero does nothing.
// - Resume request clears when resume completes or a bus reset is requested.
// - Writing one to reset request starts a bus reset.
// - Reset request clears itself when the bus reset has been sent.
// - Writing zero to reset request during a reset aborts it.
// - Clearing frame generation enable stops frames and idles the bus.
// - Enabled frame generation gives frames at full speed, keep-alive at low speed.
// - Hardware sets frame generation enable on reset request, or on upstream resume while the clock freeze bit is zero.
// - Pipe summary flags, bits 8 to 16, follow each pipe's interrupt source while the clock freeze bit is zero.
// - Wakeup flag sets when frames are off and resume or detach occurs.
// - Wakeup flag sets on attach while bus power request is one.
// - Wakeup detection keeps working while the clock freeze bit is set.
// - Frame start flag sets on each frame start or low-speed keep-alive.
// - Upstream resume flag sets when the peripheral signals resume.
// - Downstream resume done flag sets when the host finishes a resume.
// - Bus reset done flag sets when the host finishes a bus reset.
// - Detach flag sets when the peripheral is removed.
// - Attach flag sets when a peripheral is attached.
// - Writing one to the flag clear register clears that event flag.
// - Writing one to the flag set register forces that event flag.
// - A flag reaches the interrupt only while its read-only enable bit is one.
// - Writing one to the enable clear register clears that enable bit.
module uhg_host_ctrl
  import uhg_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Wishbone slave
  input  wire logic                 cyc_i,
  input  wire logic                 stb_i,
  input  wire logic                 we_i,
  input  wire logic [ADR_W-1:0]     adr_i,
  input  wire logic [3:0]           sel_i,
  input  wire logic [DAT_W-1:0]     dat_i,
  output logic      [DAT_W-1:0]     dat_o,
  output logic                      ack_o,
  // Line-side events and pipe sources
  input  wire uhg_line_evt_t        line_evt_i,
  input  wire logic [NUM_PIPES-1:0] pipe_irq_i,
  // Line-side commands
  output uhg_line_cmd_t             line_cmd_o,
  // Interrupt request
  output logic                      irq_o
);

  uhg_state_t           st_r;
  uhg_state_t           st_nxt;
  logic                 req;
  logic                 wr;
  logic                 ctrl_wr;
  logic                 aux_wr;
  logic [DAT_W-1:0]     wmask;
  logic [DAT_W-1:0]     wd;
  logic [NUM_EVT-1:0]   hw_set;
  logic [NUM_EVT-1:0]   ev_clr;
  logic [NUM_EVT-1:0]   ev_set;
  logic [EN_W-1:0]      en_clr;
  logic [EN_W-1:0]      en_set;

  // Flag register image
  function automatic logic [DAT_W-1:0] flags_word(input uhg_state_t s);
    return {15'h0000, s.pipe_summary_flag, 1'b0, s.evt};
  endfunction : flags_word

  // Enable register image
  function automatic logic [DAT_W-1:0] enables_word(input uhg_state_t s);
    return {15'h0000, s.en & EN_MASK};
  endfunction : enables_word

  // Read decode
  function automatic logic [DAT_W-1:0] read_word(input uhg_state_t s,
                                                 input logic [ADR_W-1:0] a);
    logic [DAT_W-1:0] v;
    v = RST_WORD;
    unique case (a)
      OFF_BUS_CTRL: begin
        v[CTRL_FRAME_GEN_BIT] = s.frame_gen_enable;
        v[CTRL_RESET_BIT]     = s.reset_req;
        v[CTRL_RESUME_BIT]    = s.resume_req;
      end
      OFF_FLAGS:    v = flags_word(s);
      OFF_ENABLES:  v = enables_word(s);
      OFF_AUX_CTRL: begin
        v[AUX_POWER_BIT]  = s.bus_power_request;
        v[AUX_FREEZE_BIT] = s.clock_freeze;
        v[AUX_LOWSPD_BIT] = s.low_speed;
      end
      default:      v = RST_WORD;
    endcase
    return v;
  endfunction : read_word

  always_comb begin
    st_nxt  = st_r;
    req     = cyc_i & stb_i & ~st_r.ack;
    wr      = cyc_i & stb_i & we_i & st_r.ack;
    wmask   = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    wd      = dat_i & wmask;
    ctrl_wr = wr && (adr_i == OFF_BUS_CTRL) && sel_i[1];
    aux_wr  = wr && (adr_i == OFF_AUX_CTRL) && sel_i[0];
    ev_clr  = (wr && adr_i == OFF_FLAG_CLR) ? wd[NUM_EVT-1:0] : '0;
    ev_set  = (wr && adr_i == OFF_FLAG_SET) ? wd[NUM_EVT-1:0] : '0;
    en_clr  = (wr && adr_i == OFF_ENABLE_CLR) ? (wd[EN_W-1:0] & EN_MASK) : '0;
    en_set  = (wr && adr_i == OFF_ENABLE_SET) ? (wd[EN_W-1:0] & EN_MASK) : '0;
    hw_set  = '0;

    // Bus handshake, data captured at request, write at the ack edge
    st_nxt.ack = req;
    if (req) begin
      st_nxt.dat = read_word(st_r, adr_i);
    end

    // Completion of line sequences
    if (st_r.reset_req && line_evt_i.reset_sent) begin
      st_nxt.reset_req = 1'b0;
      hw_set[FLAG_RESET_DONE] = 1'b1;
    end
    if (st_r.resume_req && line_evt_i.resume_sent) begin
      st_nxt.resume_req = 1'b0;
      hw_set[FLAG_RESUME_DONE] = 1'b1;
    end

    // Software control writes
    if (ctrl_wr) begin
      st_nxt.frame_gen_enable = dat_i[CTRL_FRAME_GEN_BIT];
      st_nxt.reset_req        = dat_i[CTRL_RESET_BIT];
      if (dat_i[CTRL_RESET_BIT]) begin
        st_nxt.frame_gen_enable = 1'b1;
        st_nxt.resume_req       = 1'b0;
      end else if (dat_i[CTRL_RESUME_BIT]) begin
        st_nxt.resume_req = 1'b1;
      end
    end
    if (aux_wr) begin
      st_nxt.bus_power_request = dat_i[AUX_POWER_BIT];
      st_nxt.clock_freeze      = dat_i[AUX_FREEZE_BIT];
      st_nxt.low_speed         = dat_i[AUX_LOWSPD_BIT];
    end

    // Line events, suppressed while the clock is frozen except wakeup
    if (!st_r.clock_freeze) begin
      hw_set[FLAG_ATTACH]      = line_evt_i.attach;
      hw_set[FLAG_DETACH]      = line_evt_i.detach;
      hw_set[FLAG_UP_RESUME]   = line_evt_i.up_resume;
      hw_set[FLAG_FRAME_START] = line_evt_i.frame_sent & st_r.frame_gen_enable;
      st_nxt.pipe_summary_flag = pipe_irq_i;
      if (line_evt_i.up_resume) begin
        st_nxt.frame_gen_enable = 1'b1;
      end
    end
    hw_set[FLAG_WAKEUP] = (~st_r.frame_gen_enable &
                           (line_evt_i.up_resume | line_evt_i.detach)) |
                          (st_r.bus_power_request & line_evt_i.attach);

    // Event flags, a set wins over a clear in the same cycle
    st_nxt.evt = (st_r.evt & ~ev_clr) | ev_set | hw_set;

    // Enables change only through their set and clear registers
    st_nxt.en = ((st_r.en & ~en_clr) | en_set) & EN_MASK;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs
  assign dat_o                    = st_r.dat;
  assign ack_o                    = st_r.ack;
  assign line_cmd_o.send_reset    = st_r.reset_req;
  assign line_cmd_o.send_resume   = st_r.resume_req;
  assign line_cmd_o.sof_gen       = st_r.frame_gen_enable & ~st_r.low_speed;
  assign line_cmd_o.keepalive_gen = st_r.frame_gen_enable & st_r.low_speed;
  assign line_cmd_o.bus_power     = st_r.bus_power_request;
  assign line_cmd_o.clock_freeze  = st_r.clock_freeze;
  assign irq_o = |(flags_word(st_r) & enables_word(st_r));

  // Checks
  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack not a single pulse");

  property p_resume_start;
    @(posedge clk_i) disable iff (rst_i)
    (ctrl_wr && dat_i[CTRL_RESUME_BIT] && !dat_i[CTRL_RESET_BIT]) |=> line_cmd_o.send_resume;
  endproperty
  a_resume_start: assert property (p_resume_start)
    else $error("resume request not taken");

  property p_reset_start;
    @(posedge clk_i) disable iff (rst_i)
    (ctrl_wr && dat_i[CTRL_RESET_BIT]) |=>
      (line_cmd_o.send_reset && !line_cmd_o.send_resume && st_r.frame_gen_enable);
  endproperty
  a_reset_start: assert property (p_reset_start)
    else $error("reset request did not start correctly");

  property p_reset_done;
    @(posedge clk_i) disable iff (rst_i)
    (st_r.reset_req && line_evt_i.reset_sent && !ctrl_wr) |=>
      (!line_cmd_o.send_reset && st_r.evt[FLAG_RESET_DONE]);
  endproperty
  a_reset_done: assert property (p_reset_done)
    else $error("reset completion mishandled");

  property p_reset_abort;
    @(posedge clk_i) disable iff (rst_i)
    (ctrl_wr && !dat_i[CTRL_RESET_BIT]) |=> !line_cmd_o.send_reset;
  endproperty
  a_reset_abort: assert property (p_reset_abort)
    else $error("reset not aborted");

  property p_resume_done;
    @(posedge clk_i) disable iff (rst_i)
    (st_r.resume_req && line_evt_i.resume_sent && !ctrl_wr) |=>
      (!line_cmd_o.send_resume && st_r.evt[FLAG_RESUME_DONE]);
  endproperty
  a_resume_done: assert property (p_resume_done)
    else $error("resume completion mishandled");

  property p_frame_off_idle;
    @(posedge clk_i) disable iff (rst_i)
    (ctrl_wr && !dat_i[CTRL_FRAME_GEN_BIT] && !dat_i[CTRL_RESET_BIT] &&
     !line_evt_i.up_resume) |=> (!line_cmd_o.sof_gen && !line_cmd_o.keepalive_gen);
  endproperty
  a_frame_off_idle: assert property (p_frame_off_idle)
    else $error("bus not idle after frame disable");

  property p_up_resume;
    @(posedge clk_i) disable iff (rst_i)
    (line_evt_i.up_resume && !st_r.clock_freeze) |=>
      (st_r.evt[FLAG_UP_RESUME] && st_r.frame_gen_enable);
  endproperty
  a_up_resume: assert property (p_up_resume)
    else $error("upstream resume not recorded");

  property p_wakeup;
    @(posedge clk_i) disable iff (rst_i)
    ((!st_r.frame_gen_enable && (line_evt_i.detach || line_evt_i.up_resume)) ||
     (st_r.bus_power_request && line_evt_i.attach)) |=> st_r.evt[FLAG_WAKEUP];
  endproperty
  a_wakeup: assert property (p_wakeup)
    else $error("wakeup flag not raised");

  property p_pipe_follow;
    @(posedge clk_i) disable iff (rst_i)
    !st_r.clock_freeze |=> (st_r.pipe_summary_flag == $past(pipe_irq_i));
  endproperty
  a_pipe_follow: assert property (p_pipe_follow)
    else $error("pipe summary flag mismatch");

  property p_line_flags;
    @(posedge clk_i) disable iff (rst_i)
    !st_r.clock_freeze |=>
      ((!$past(line_evt_i.frame_sent && st_r.frame_gen_enable) ||
        st_r.evt[FLAG_FRAME_START]) &&
       (!$past(line_evt_i.attach) || st_r.evt[FLAG_ATTACH]) &&
       (!$past(line_evt_i.detach) || st_r.evt[FLAG_DETACH]));
  endproperty
  a_line_flags: assert property (p_line_flags)
    else $error("line event flag missing");

  property p_flag_clear;
    @(posedge clk_i) disable iff (rst_i)
    (ev_clr[FLAG_ATTACH] && !line_evt_i.attach) |=> !st_r.evt[FLAG_ATTACH];
  endproperty
  a_flag_clear: assert property (p_flag_clear)
    else $error("flag clear ignored");

  property p_flag_set;
    @(posedge clk_i) disable iff (rst_i)
    (ev_set != '0) |=> ((st_r.evt & $past(ev_set)) == $past(ev_set));
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("flag set ignored");

  property p_enable_clear;
    @(posedge clk_i) disable iff (rst_i)
    (en_clr != '0) |=> ((st_r.en & $past(en_clr)) == '0);
  endproperty
  a_enable_clear: assert property (p_enable_clear)
    else $error("enable clear ignored");

  property p_irq_gate;
    @(posedge clk_i) disable iff (rst_i)
    (st_r.en == '0) |-> !irq_o;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt without enable");

  property p_irq_raise;
    @(posedge clk_i) disable iff (rst_i)
    (st_r.en[FLAG_WAKEUP] && st_r.evt[FLAG_WAKEUP]) |-> irq_o;
  endproperty
  a_irq_raise: assert property (p_irq_raise)
    else $error("enabled flag gave no interrupt");

endmodule : uhg_host_ctrl

/* logic/uhg_pkg.sv */
package uhg_pkg;

  // Bus geometry
  localparam int ADR_W = 12;
  localparam int DAT_W = 32;

  // Register byte offsets
  localparam logic [ADR_W-1:0] OFF_BUS_CTRL   = 12'h400;
  localparam logic [ADR_W-1:0] OFF_FLAGS      = 12'h404;
  localparam logic [ADR_W-1:0] OFF_FLAG_CLR   = 12'h408;
  localparam logic [ADR_W-1:0] OFF_FLAG_SET   = 12'h40c;
  localparam logic [ADR_W-1:0] OFF_ENABLES    = 12'h410;
  localparam logic [ADR_W-1:0] OFF_ENABLE_CLR = 12'h414;
  localparam logic [ADR_W-1:0] OFF_ENABLE_SET = 12'h418;
  localparam logic [ADR_W-1:0] OFF_AUX_CTRL   = 12'h420;

  // Bus control fields
  localparam int CTRL_FRAME_GEN_BIT = 8;
  localparam int CTRL_RESET_BIT     = 9;
  localparam int CTRL_RESUME_BIT    = 10;

  // Auxiliary control fields
  localparam int AUX_POWER_BIT  = 0;
  localparam int AUX_FREEZE_BIT = 1;
  localparam int AUX_LOWSPD_BIT = 2;

  // Event flag positions
  localparam int FLAG_ATTACH      = 0;
  localparam int FLAG_DETACH      = 1;
  localparam int FLAG_RESET_DONE  = 2;
  localparam int FLAG_RESUME_DONE = 3;
  localparam int FLAG_UP_RESUME   = 4;
  localparam int FLAG_FRAME_START = 5;
  localparam int FLAG_WAKEUP      = 6;
  localparam int NUM_EVT          = 7;
  localparam int PIPE_LSB         = 8;
  localparam int NUM_PIPES        = 9;
  localparam int EN_W             = PIPE_LSB + NUM_PIPES;

  // Implemented enable bits
  localparam logic [EN_W-1:0] EN_MASK = 17'h1ff7f;

  // Reset values
  localparam logic [DAT_W-1:0] RST_WORD = 32'h0000_0000;

  // Complete block state
  typedef struct packed {
    logic                  frame_gen_enable;
    logic                  reset_req;
    logic                  resume_req;
    logic                  bus_power_request;
    logic                  clock_freeze;
    logic                  low_speed;
    logic [NUM_EVT-1:0]    evt;
    logic [NUM_PIPES-1:0]  pipe_summary_flag;
    logic [EN_W-1:0]       en;
    logic                  ack;
    logic [DAT_W-1:0]      dat;
  } uhg_state_t;

  // Line-side event strobes
  typedef struct packed {
    logic attach;
    logic detach;
    logic up_resume;
    logic frame_sent;
    logic reset_sent;
    logic resume_sent;
  } uhg_line_evt_t;

  // Line-side commands
  typedef struct packed {
    logic send_reset;
    logic send_resume;
    logic sof_gen;
    logic keepalive_gen;
    logic bus_power;
    logic clock_freeze;
  } uhg_line_cmd_t;

endpackage : uhg_pkg
